// ===== hw/iso_irq_events.sv
// iso receive channel mask and upper interrupt event flags, apb slave
`timescale 1ns/100ps
module iso_irq_events #(
  parameter int unsigned OVERLONG_CYCLES = iso_irq_pkg::OVERLONG_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // iso receive header filter
  input wire logic iso_hdr_valid,
  input wire logic [5:0] iso_hdr_chan,
  output logic iso_accept,
  // general purpose interrupt inputs
  input wire logic gp_irq_a,
  input wire logic gp_irq_b,
  // phy register byte
  input wire logic phy_byte_valid,
  input wire logic [7:0] phy_byte,
  // cycle timing
  input wire logic [31:0] cyc_timer,
  input wire logic cs_tx_start,
  input wire logic cs_rx_valid,
  input wire logic [6:0] cs_rx_secs,
  input wire logic [12:0] cs_rx_count,
  input wire logic subaction_gap,
  input wire logic arb_reset_gap,
  // dma context faults
  input wire logic [iso_irq_pkg::CTX_N-1:0] ctx_dead,
  output logic [iso_irq_pkg::CTX_N-1:0] ctx_irq_block,
  // status out
  output logic period_leader_enable,
  output logic irq
);

  typedef struct packed {
    logic [31:0] chan_mask;
    logic [31:0] ev;
    logic [31:0] ev_mask;
    logic [2:0] ctrl;
    logic [7:0] phy_data;
    logic [iso_irq_pkg::CTX_N-1:0] fault_ctx;
    logic [iso_irq_pkg::CTX_N-1:0] dead_prev;
    logic gpa_prev;
    logic gpb_prev;
    logic armed;
    logic secs6_prev;
    logic cnt0_prev;
    logic seen_sync;
    logic cs_seen;
    logic gap_seen;
    iso_irq_pkg::lead_st_e lst;
    logic [iso_irq_pkg::LCNT_W-1:0] lcnt;
    logic [31:0] prdata;
    logic slverr;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == iso_irq_pkg::OFF_CHAN_SET) || (a == iso_irq_pkg::OFF_CHAN_CLR) ||
                (a == iso_irq_pkg::OFF_EV_SET) || (a == iso_irq_pkg::OFF_EV_CLR) ||
                (a == iso_irq_pkg::OFF_EV_MASK) || (a == iso_irq_pkg::OFF_CTRL) ||
                (a == iso_irq_pkg::OFF_EV_RAW) || (a == iso_irq_pkg::OFF_PHY);
  endfunction : is_mapped

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input state_s s);
    rd_mux = 32'h0000_0000;
    case (a)
      iso_irq_pkg::OFF_CHAN_SET, iso_irq_pkg::OFF_CHAN_CLR: rd_mux = s.chan_mask;
      iso_irq_pkg::OFF_EV_SET, iso_irq_pkg::OFF_EV_CLR: begin
        rd_mux = s.ev & s.ev_mask & iso_irq_pkg::EV_IMPL;
      end
      iso_irq_pkg::OFF_EV_MASK: rd_mux = s.ev_mask;
      iso_irq_pkg::OFF_CTRL: rd_mux = {29'h0000_0000, s.ctrl};
      iso_irq_pkg::OFF_EV_RAW: rd_mux = s.ev;
      iso_irq_pkg::OFF_PHY: rd_mux = {8'h00, s.phy_data, 16'h0000};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  logic wr_acc;
  logic new_period;
  logic secs6_chg;
  logic [31:0] sw_set;
  logic [31:0] sw_clr;
  logic [31:0] hw_set;
  logic [iso_irq_pkg::CTX_N-1:0] dead_rise;
  logic overlong;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sw_set = 32'h0000_0000;
    sw_clr = 32'h0000_0000;
    hw_set = 32'h0000_0000;
    overlong = 1'b0;
    wr_acc = psel && penable && pwrite;
    // timer edges are meaningless until one sample has been taken
    new_period = st_r.armed && (cyc_timer[iso_irq_pkg::CNT_LSB] != st_r.cnt0_prev);
    secs6_chg = st_r.armed && (cyc_timer[iso_irq_pkg::SECS_MSB] != st_r.secs6_prev);
    dead_rise = ctx_dead & ~st_r.dead_prev;

    // read data and error latched in setup, shown in access
    if (psel && !penable) begin
      st_nxt.prdata = rd_mux(paddr, st_r);
      st_nxt.slverr = !is_mapped(paddr);
    end

    // register writes take effect at the access edge
    if (wr_acc) begin
      case (paddr)
        iso_irq_pkg::OFF_CHAN_SET: st_nxt.chan_mask = st_r.chan_mask | pwdata;
        iso_irq_pkg::OFF_CHAN_CLR: st_nxt.chan_mask = st_r.chan_mask & ~pwdata;
        iso_irq_pkg::OFF_EV_SET: sw_set = pwdata;
        iso_irq_pkg::OFF_EV_CLR: sw_clr = pwdata;
        iso_irq_pkg::OFF_EV_MASK: st_nxt.ev_mask = pwdata & iso_irq_pkg::EV_IMPL;
        iso_irq_pkg::OFF_CTRL: st_nxt.ctrl = pwdata[2:0];
        default: st_nxt.ctrl = st_nxt.ctrl;
      endcase
    end

    // hardware event sources, edge detected where they are levels
    hw_set[iso_irq_pkg::EV_GP] = (gp_irq_a && !st_r.gpa_prev && st_r.ctrl[iso_irq_pkg::CTL_GPA]) ||
                                 (gp_irq_b && !st_r.gpb_prev && st_r.ctrl[iso_irq_pkg::CTL_GPB]);
    hw_set[iso_irq_pkg::EV_PHY] = phy_byte_valid;
    hw_set[iso_irq_pkg::EV_FATAL] = |dead_rise;
    hw_set[iso_irq_pkg::EV_MISMATCH] = cs_rx_valid &&
      ((cs_rx_secs != cyc_timer[iso_irq_pkg::SECS_MSB:iso_irq_pkg::SECS_LSB]) ||
       (cs_rx_count != cyc_timer[iso_irq_pkg::CNT_MSB:iso_irq_pkg::CNT_LSB]));
    hw_set[iso_irq_pkg::EV_SECS6] = secs6_chg;
    hw_set[iso_irq_pkg::EV_SYNC] = new_period;

    // lost period: judged at the synch, or predicted earlier
    if (new_period && st_r.seen_sync && !st_r.cs_seen) begin
      hw_set[iso_irq_pkg::EV_LOST] = 1'b1;
    end
    if (!st_r.cs_seen && st_r.seen_sync && !new_period &&
        ((subaction_gap && st_r.gap_seen) || arb_reset_gap)) begin
      hw_set[iso_irq_pkg::EV_LOST] = 1'b1;
    end

    // period bookkeeping; a start in the synch cycle counts for the new one
    if (new_period) begin
      st_nxt.seen_sync = 1'b1;
      st_nxt.cs_seen = cs_tx_start || cs_rx_valid;
      st_nxt.gap_seen = 1'b0;
    end else begin
      if (cs_tx_start || cs_rx_valid) begin
        st_nxt.cs_seen = 1'b1;
      end
      if (subaction_gap) begin
        st_nxt.gap_seen = 1'b1;
      end
    end

    // overlong leader period watchdog
    case (st_r.lst)
      iso_irq_pkg::LEAD_IDLE: begin
        if (st_r.ctrl[iso_irq_pkg::CTL_LEADER] && cs_tx_start) begin
          st_nxt.lst = iso_irq_pkg::LEAD_TIMING;
          st_nxt.lcnt = '0;
        end
      end
      iso_irq_pkg::LEAD_TIMING: begin
        if (subaction_gap || !st_r.ctrl[iso_irq_pkg::CTL_LEADER]) begin
          st_nxt.lst = iso_irq_pkg::LEAD_IDLE;
        end else if (st_r.lcnt >= iso_irq_pkg::LCNT_W'(OVERLONG_CYCLES)) begin
          overlong = 1'b1;
          st_nxt.lst = iso_irq_pkg::LEAD_IDLE;
        end else begin
          st_nxt.lcnt = st_r.lcnt + 1'b1;
        end
      end
      default: st_nxt.lst = iso_irq_pkg::LEAD_IDLE;
    endcase
    hw_set[iso_irq_pkg::EV_LONG] = overlong;
    if (overlong) begin
      st_nxt.ctrl[iso_irq_pkg::CTL_LEADER] = 1'b0;
    end

    // sticky flags: a set in the clearing cycle wins; reserved stay zero
    st_nxt.ev = ((st_r.ev & ~sw_clr) | hw_set | sw_set) & iso_irq_pkg::EV_IMPL;

    // faulting contexts are remembered until the fatal flag is cleared
    if (!st_nxt.ev[iso_irq_pkg::EV_FATAL]) begin
      st_nxt.fault_ctx = '0;
    end else begin
      st_nxt.fault_ctx = st_r.fault_ctx | dead_rise;
    end

    if (phy_byte_valid) begin
      st_nxt.phy_data = phy_byte;
    end

    // edge history
    st_nxt.dead_prev = ctx_dead;
    st_nxt.gpa_prev = gp_irq_a;
    st_nxt.gpb_prev = gp_irq_b;
    st_nxt.secs6_prev = cyc_timer[iso_irq_pkg::SECS_MSB];
    st_nxt.cnt0_prev = cyc_timer[iso_irq_pkg::CNT_LSB];
    st_nxt.armed = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register, synchronous reset
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.chan_mask <= iso_irq_pkg::MASK_RST;
      st_r.ev <= iso_irq_pkg::EV_RST;
      st_r.ctrl <= iso_irq_pkg::CTRL_RST;
      st_r.lst <= iso_irq_pkg::LEAD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states keeps the bus simple; data is already latched
  assign pready = 1'b1;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.slverr;
  // only channels 0..31 live in this mask
  assign iso_accept = iso_hdr_valid && !iso_hdr_chan[5] && st_r.chan_mask[iso_hdr_chan[4:0]];
  assign ctx_irq_block = st_r.ev[iso_irq_pkg::EV_FATAL] ? st_r.fault_ctx : '0;
  assign period_leader_enable = st_r.ctrl[iso_irq_pkg::CTL_LEADER];
  assign irq = |(st_r.ev & st_r.ev_mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_chan_set;
    (wr_acc && paddr == iso_irq_pkg::OFF_CHAN_SET) |=> ((st_r.chan_mask & $past(pwdata)) == $past(pwdata));
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("mask set write lost");

  property p_chan_clr;
    (wr_acc && paddr == iso_irq_pkg::OFF_CHAN_CLR) |=> ((st_r.chan_mask & $past(pwdata)) == 32'h0000_0000);
  endproperty
  a_chan_clr: assert property (p_chan_clr) else $error("mask clear write lost");

  property p_accept;
    iso_accept |-> (iso_hdr_chan < 6'(iso_irq_pkg::CHAN_N)) && st_r.chan_mask[iso_hdr_chan[4:0]];
  endproperty
  a_accept: assert property (p_accept) else $error("disabled channel accepted");

  property p_only_clear;
    |($past(st_r.ev) & ~st_r.ev) |-> $past(wr_acc && paddr == iso_irq_pkg::OFF_EV_CLR);
  endproperty
  a_only_clear: assert property (p_only_clear) else $error("flag dropped without clear");

  property p_sw_set;
    (wr_acc && paddr == iso_irq_pkg::OFF_EV_SET) |=>
      ((st_r.ev & $past(pwdata) & iso_irq_pkg::EV_IMPL) == ($past(pwdata) & iso_irq_pkg::EV_IMPL));
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("event set write lost");

  property p_ev_read;
    (psel && !penable && paddr == iso_irq_pkg::OFF_EV_CLR) |=> (prdata == $past(st_r.ev & st_r.ev_mask));
  endproperty
  a_ev_read: assert property (p_ev_read) else $error("event read not masked");

  property p_reserved;
    (st_r.ev & ~iso_irq_pkg::EV_IMPL) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved event bit set");

  property p_overlong;
    (st_r.lst == iso_irq_pkg::LEAD_TIMING && st_r.ctrl[iso_irq_pkg::CTL_LEADER] && !subaction_gap &&
     st_r.lcnt >= iso_irq_pkg::LCNT_W'(OVERLONG_CYCLES))
      |=> st_r.ev[iso_irq_pkg::EV_LONG] && !period_leader_enable;
  endproperty
  a_overlong: assert property (p_overlong) else $error("overlong period missed");

  property p_phy;
    phy_byte_valid |=> st_r.ev[iso_irq_pkg::EV_PHY] && (st_r.phy_data == $past(phy_byte));
  endproperty
  a_phy: assert property (p_phy) else $error("phy byte not flagged");

  property p_fatal;
    (|dead_rise) |=> st_r.ev[iso_irq_pkg::EV_FATAL] &&
      ((ctx_irq_block & $past(dead_rise)) == $past(dead_rise));
  endproperty
  a_fatal: assert property (p_fatal) else $error("context fault not blocked");

  property p_secs6;
    (st_r.armed && cyc_timer[iso_irq_pkg::SECS_MSB] != st_r.secs6_prev) |=> st_r.ev[iso_irq_pkg::EV_SECS6];
  endproperty
  a_secs6: assert property (p_secs6) else $error("seconds bit change missed");

  property p_lost;
    (new_period && st_r.seen_sync && !st_r.cs_seen) |=> st_r.ev[iso_irq_pkg::EV_LOST];
  endproperty
  a_lost: assert property (p_lost) else $error("lost period not flagged");

  c_overlong: cover property (overlong);
  c_lost: cover property (new_period && st_r.seen_sync && !st_r.cs_seen);
  c_irq: cover property ($rose(irq));
  c_accept: cover property (iso_accept);

endmodule : iso_irq_events

// ===== hw/iso_irq_pkg.sv
// constants and types for the iso channel mask and event flag block
package iso_irq_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CHAN_SET = 12'h078;
  localparam logic [11:0] OFF_CHAN_CLR = 12'h07c;
  localparam logic [11:0] OFF_EV_SET = 12'h080;
  localparam logic [11:0] OFF_EV_CLR = 12'h084;
  localparam logic [11:0] OFF_EV_MASK = 12'h088;
  localparam logic [11:0] OFF_CTRL = 12'h08c;
  localparam logic [11:0] OFF_EV_RAW = 12'h090;
  localparam logic [11:0] OFF_PHY = 12'h094;

  // ----------------------------------------------------------------
  // event bit positions and implemented set
  // ----------------------------------------------------------------
  localparam int EV_GP = 30;
  localparam int EV_PHY = 26;
  localparam int EV_LONG = 25;
  localparam int EV_FATAL = 24;
  localparam int EV_MISMATCH = 23;
  localparam int EV_LOST = 22;
  localparam int EV_SECS6 = 21;
  localparam int EV_SYNC = 20;
  localparam logic [31:0] EV_IMPL = 32'h47f0_0000;

  // ----------------------------------------------------------------
  // control bits, fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_LEADER = 0;
  localparam int CTL_GPA = 1;
  localparam int CTL_GPB = 2;
  localparam int PHY_LSB = 16;
  localparam int SECS_MSB = 31;
  localparam int SECS_LSB = 25;
  localparam int CNT_MSB = 24;
  localparam int CNT_LSB = 12;
  localparam int CHAN_N = 32;
  localparam int CTX_N = 4;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] EV_RST = 32'h0000_0000;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int OVERLONG_NS = 125000;
  localparam int OVERLONG_CYC = (OVERLONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int LCNT_W = 16;

  typedef enum logic {LEAD_IDLE, LEAD_TIMING} lead_st_e;

endpackage : iso_irq_pkg

// ===== testbench/tb_top.sv
// self-checking bench for the iso channel mask and event flag block
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // signals and design instance
  // ----------------------------------------------------------------
  localparam int unsigned OVL = 20; // short overlong count keeps the run brief
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, iso_hdr_valid, iso_accept;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cyc_timer, r, m, s, c;
  logic [5:0] iso_hdr_chan;
  logic gp_irq_a, gp_irq_b, phy_byte_valid, cs_tx_start, cs_rx_valid, subaction_gap, arb_reset_gap;
  logic period_leader_enable, irq, err_seen;
  logic [7:0] phy_byte;
  logic [6:0] cs_rx_secs;
  logic [12:0] cs_rx_count;
  logic [3:0] ctx_dead, ctx_irq_block;
  int fail_count = 0;
  int checks_done = 0;

  iso_irq_events #(.OVERLONG_CYCLES(OVL)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .iso_hdr_valid(iso_hdr_valid),
    .iso_hdr_chan(iso_hdr_chan), .iso_accept(iso_accept), .gp_irq_a(gp_irq_a), .gp_irq_b(gp_irq_b),
    .phy_byte_valid(phy_byte_valid), .phy_byte(phy_byte), .cyc_timer(cyc_timer), .cs_tx_start(cs_tx_start),
    .cs_rx_valid(cs_rx_valid), .cs_rx_secs(cs_rx_secs), .cs_rx_count(cs_rx_count),
    .subaction_gap(subaction_gap), .arb_reset_gap(arb_reset_gap), .ctx_dead(ctx_dead),
    .ctx_irq_block(ctx_irq_block), .period_leader_enable(period_leader_enable), .irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // one apb transfer; request held until pready seen at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait count assumed; a slave that never answers is caught by the watchdog
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(a, 1'b1, d, x);
  endtask : wr

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // raw flags compared, then every flag cleared
  task automatic ev_is(input logic [31:0] exp);
    tick(2);
    apb(iso_irq_pkg::OFF_EV_RAW, 1'b0, 32'h0, r);
    chk("raw events", r, exp);
    chk("bus error", {31'h0, err_seen}, 32'h0);
    wr(iso_irq_pkg::OFF_EV_CLR, 32'hffff_ffff);
  endtask : ev_is

  function automatic logic exp_acc(input logic [31:0] mk, input logic [5:0] ch);
    return (ch < 6'd32) && mk[ch[4:0]];
  endfunction : exp_acc

  // ----------------------------------------------------------------
  // clock, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, iso_hdr_valid, gp_irq_a, gp_irq_b, phy_byte_valid} = '0;
    {cs_tx_start, cs_rx_valid, subaction_gap, arb_reset_gap} = '0;
    paddr = '0; pwdata = '0; iso_hdr_chan = '0; phy_byte = '0; cyc_timer = '0;
    cs_rx_secs = '0; cs_rx_count = '0; ctx_dead = '0; m = '0;
    void'($urandom(1));
    tick(12);
    rst_n <= 1'b1;
    apb(iso_irq_pkg::OFF_CHAN_SET, 1'b0, 32'h0, r);
    chk("mask after reset", r, iso_irq_pkg::MASK_RST);
    ev_is(32'h0);
    // random set/clear traffic, then corner channels plus random ones
    for (int i = 0; i < 8; i++) begin
      s = (i == 7) ? 32'h8000_0001 : $urandom;
      c = (i == 7) ? 32'h7fff_fffe : $urandom;
      wr(iso_irq_pkg::OFF_CHAN_SET, s);
      wr(iso_irq_pkg::OFF_CHAN_CLR, c);
      m = (m | s) & ~c;
      apb(iso_irq_pkg::OFF_CHAN_CLR, 1'b0, 32'h0, r);
      chk("mask", r, m);
      for (int k = 0; k < 6; k++) begin
        @(posedge sys_clk);
        iso_hdr_valid <= 1'b1;
        // corners 0, 31, 32 and 63 first, then random channels
        case (k)
          0: iso_hdr_chan <= 6'd0;
          1: iso_hdr_chan <= 6'd31;
          2: iso_hdr_chan <= 6'd32;
          3: iso_hdr_chan <= 6'd63;
          default: iso_hdr_chan <= 6'($urandom);
        endcase
        #1 chk("accept", {31'h0, iso_accept}, {31'h0, exp_acc(m, iso_hdr_chan)});
      end
      @(posedge sys_clk);
      iso_hdr_valid <= 1'b0;
    end
    // set everything while masked, then unmask
    wr(iso_irq_pkg::OFF_EV_SET, 32'hffff_ffff);
    apb(iso_irq_pkg::OFF_EV_SET, 1'b0, 32'h0, r);
    chk("masked read", r, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(iso_irq_pkg::OFF_EV_MASK, 32'hffff_ffff);
    apb(iso_irq_pkg::OFF_EV_MASK, 1'b0, 32'h0, r);
    chk("mask reg", r, iso_irq_pkg::EV_IMPL);
    for (int i = 0; i < 2; i++) begin
      apb(iso_irq_pkg::OFF_EV_CLR, 1'b0, 32'h0, r);
      chk("unmasked read", r, iso_irq_pkg::EV_IMPL);
    end
    chk("irq up", {31'h0, irq}, 32'h1);
    wr(iso_irq_pkg::OFF_EV_CLR, 32'h0400_0000);
    ev_is(iso_irq_pkg::EV_IMPL & 32'hfbff_ffff);
    // general purpose inputs, disabled then each enabled
    for (int i = 0; i < 3; i++) begin
      wr(iso_irq_pkg::OFF_CTRL, (i == 0) ? 32'h0 : 32'(2 * i));
      @(posedge sys_clk);
      if (i == 2) gp_irq_b <= 1'b1;
      else gp_irq_a <= 1'b1;
      @(posedge sys_clk);
      {gp_irq_a, gp_irq_b} <= 2'b00;
      ev_is((i == 0) ? 32'h0 : 32'h4000_0000);
    end
    // phy byte
    @(posedge sys_clk);
    phy_byte <= 8'($urandom);
    phy_byte_valid <= 1'b1;
    @(posedge sys_clk);
    phy_byte_valid <= 1'b0;
    tick(2);
    apb(iso_irq_pkg::OFF_PHY, 1'b0, 32'h0, r);
    chk("phy byte", {24'h0, r[23:16]}, {24'h0, phy_byte});
    ev_is(32'h0400_0000);
    // leader period: gap in time, then overlong
    wr(iso_irq_pkg::OFF_CTRL, 32'h1);
    apb(iso_irq_pkg::OFF_CTRL, 1'b0, 32'h0, r);
    chk("ctrl reg", r, 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      cs_tx_start <= 1'b1;
      @(posedge sys_clk);
      cs_tx_start <= 1'b0;
      tick((i == 0) ? 5 : OVL + 10);
      subaction_gap <= (i == 0);
      @(posedge sys_clk);
      subaction_gap <= 1'b0;
      #1 chk("leader", {31'h0, period_leader_enable}, {31'h0, i == 0});
      ev_is((i == 0) ? 32'h0 : 32'h0200_0000);
    end
    // context halt
    @(posedge sys_clk);
    ctx_dead <= 4'h2;
    tick(3);
    chk("ctx block", {28'h0, ctx_irq_block}, 32'h2);
    ev_is(32'h0100_0000);
    ctx_dead <= 4'h0;
    tick(2);
    chk("ctx release", {28'h0, ctx_irq_block}, 32'h0);
    // received cycle start: match, seconds off, count off
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      cs_rx_secs <= cyc_timer[31:25] ^ ((i == 1) ? 7'(1 + $urandom % 127) : 7'h0);
      cs_rx_count <= cyc_timer[24:12] ^ ((i == 2) ? 13'h1000 : 13'h0);
      cs_rx_valid <= 1'b1;
      @(posedge sys_clk);
      cs_rx_valid <= 1'b0;
      ev_is((i == 0) ? 32'h0 : 32'h0080_0000);
    end
    // new periods: first seen, lost, then kept by a cycle start
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        @(posedge sys_clk);
        cs_tx_start <= 1'b1;
        @(posedge sys_clk);
        cs_tx_start <= 1'b0;
      end
      @(posedge sys_clk);
      cyc_timer <= cyc_timer ^ 32'h0000_1000;
      ev_is((i == 1) ? 32'h0050_0000 : 32'h0010_0000);
    end
    @(posedge sys_clk);
    cyc_timer <= cyc_timer ^ 32'h8000_0000;
    ev_is(32'h0020_0000);
    // predicted loss: reset gap, then a second gap with no start between
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      arb_reset_gap <= (i == 0);
      subaction_gap <= (i == 1);
      @(posedge sys_clk);
      arb_reset_gap <= 1'b0;
      subaction_gap <= 1'b0;
      @(posedge sys_clk);
      subaction_gap <= (i == 1);
      @(posedge sys_clk);
      subaction_gap <= 1'b0;
      ev_is(32'h0040_0000);
    end
    // unmapped and read-only places
    apb(12'h0a0, 1'b0, 32'h0, r);
    chk("unmapped err", {31'h0, err_seen}, 32'h1);
    wr(iso_irq_pkg::OFF_EV_RAW, 32'hffff_ffff);
    ev_is(32'h0);
    test_done();
  end
endmodule : tb_top
